/* File: verilog/tfsr_regs.sv */
// Interrupt mask, live status, integrity, reinit and driver-limit register bank
// Function
// - Wake mask clear: interrupt pin active while wake flag is set.
// - Wake mask set: interrupt pin pulses about 200 us per wake.
// - Five fault masks: 0 lets flag drive interrupt, 1 blocks it.
// - Driver fault status is 1 during overcurrent lasting past the blanking time, or during thermal overload.
// - Supply warning status is 1 while supply is below 16 V.
// - Undervoltage status sets below 6 V, clears above 7 V.
// - Overheat status is 1 while die exceeds shutdown threshold.
// - Temperature warning sets above 140 C, clears below 125 C.
// - Corrupt flag: driver off, outputs tri-stated, 3.3 V forced, fixed clock.
// - Writing reinit bit restores all registers; the bit clears itself.
// - With limiting on, level field selects 50/100/200/250 mA.
// - Limit-off bit disables limiting and ignores the level field.
// - Blanking field selects 128 us, 500 us, 1 ms or 5 ms.
// - Auto-retry off-time field selects 50/100/200/500 ms.
// - Auto-retry disabled: driver switched off only for thermal overload.
// - Auto-retry enabled: a driver fault (overcurrent or thermal overload) disables driver for off-time, then re-enables.
// - Interrupt flags latch their events and clear when read.
// - Power-loss flag has no mask and always drives the interrupt.
module tfsr_regs
   import tfsr_pkg::*;
#(
   // Timings in 1 us ticks; shorten for simulation
   parameter logic [7:0]       WAKE_TICKS  = 8'(WAKE_US),
   parameter logic [3:0][12:0] BLANK_TICKS = {13'(BLANK3_US), 13'(BLANK2_US),
                                              13'(BLANK1_US), 13'(BLANK0_US)},
   parameter logic [3:0][18:0] RETRY_TICKS = {19'(RETRY3_MS * 1000), 19'(RETRY2_MS * 1000),
                                              19'(RETRY1_MS * 1000), 19'(RETRY0_MS * 1000)}
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Two-wire host bus
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // Line levels and comparators
   input  wire logic       line_low,
   input  wire logic       aux_low,
   input  wire logic       drv_overcurrent,
   input  wire logic       drv_overtemp,
   input  wire logic       supply_below_16v,
   input  wire logic       supply_below_6v,
   input  wire logic       supply_above_7v,
   input  wire logic       die_above_shutdown,
   input  wire logic       die_above_140c,
   input  wire logic       die_below_125c,
   // Event pulses
   input  wire logic       wake_detect,
   input  wire logic       power_loss_event,
   input  wire logic       corrupt_event,
   // Driver control
   output logic            drv_enable,
   output logic [1:0]      limit_level_field,
   output logic            limit_off_bit,
   // Safe-state controls
   output logic            rx_oe,
   output logic            aux_input_logic_out_oe,
   output logic            regulator_3v3_force,
   output logic            clk_fixed_sel,
   // Interrupt / wake pin
   output logic            interrupt_wake_out_n
);

   tfsr_bus_s   bus;
   tfsr_limit_s limit_ff,  nxt_limit;
   logic [7:0]  mask_ff,   nxt_mask;
   logic [7:0]  flags_ff,  nxt_flags;
   logic [7:0]  prev_ff,   nxt_prev;
   logic [7:0]  wake_ff,   nxt_wake;
   logic [5:0]  tick_ff,   nxt_tick;
   logic [12:0] blank_ff,  nxt_blank;
   logic [18:0] retry_ff,  nxt_retry;
   logic        uv_ff,     nxt_uv;
   logic        twarn_ff,  nxt_twarn;
   logic        off_ff,    nxt_off;
   logic        corr_ff,   nxt_corr;
   logic        reinit_ff, nxt_reinit;
   logic        por_ff;
   logic [7:0]  live, ev, rd_data;
   logic        tick, oc_fault, drv_fault, flag_rd;

   // ------------------------------------------------------------
   // Host bus slave
   // ------------------------------------------------------------
   tfsr_i2c_slave u_bus (
      .mclk    (mclk),
      .resetn  (resetn),
      .scl     (scl),
      .sda_in  (sda_in),
      .sda_out (sda_out),
      .sda_oe  (sda_oe),
      .bus     (bus),
      .rd_data (rd_data)
   );

   // ------------------------------------------------------------
   // Status conditioning
   // ------------------------------------------------------------
   assign tick = (tick_ff == 6'(TICK_CYC - 1));

   // Hysteresis is held here so comparator chatter cannot toggle the bits
   always_comb begin
      nxt_tick  = tick ? 6'h00 : tick_ff + 6'h01;
      nxt_uv    = uv_ff;
      nxt_twarn = twarn_ff;
      nxt_blank = blank_ff;
      nxt_prev  = live;
      if (supply_below_6v) nxt_uv = 1'b1;
      else if (supply_above_7v) nxt_uv = 1'b0;
      if (die_above_140c) nxt_twarn = 1'b1;
      else if (die_below_125c) nxt_twarn = 1'b0;
      // Overcurrent must persist for the blanking time to count
      if (!drv_overcurrent) nxt_blank = 13'h0000;
      else if (tick && !oc_fault) nxt_blank = blank_ff + 13'h0001;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tick_ff  <= 6'h00;
         uv_ff    <= 1'b0;
         twarn_ff <= 1'b0;
         blank_ff <= 13'h0000;
         prev_ff  <= 8'h00;
      end else begin
         tick_ff  <= nxt_tick;
         uv_ff    <= nxt_uv;
         twarn_ff <= nxt_twarn;
         blank_ff <= nxt_blank;
         prev_ff  <= nxt_prev;
      end
   end

   assign oc_fault  = drv_overcurrent && (blank_ff >= BLANK_TICKS[limit_ff.blank]);
   assign drv_fault = oc_fault | drv_overtemp;

   // Live condition byte
   assign live = {line_low, aux_low, 1'b0, drv_fault,
                  supply_below_16v,
                  uv_ff,
                  die_above_shutdown,
                  twarn_ff};

   // ------------------------------------------------------------
   // Driver off-time and retry
   // ------------------------------------------------------------
   always_comb begin
      nxt_off   = off_ff;
      nxt_retry = retry_ff;
      if (!limit_ff.retry_en) begin
         nxt_off   = 1'b0;
         nxt_retry = 19'h00000;
      end else if (!off_ff) begin
         if (drv_fault) begin
            nxt_off   = 1'b1;
            nxt_retry = 19'h00000;
         end
      end else if (retry_ff >= RETRY_TICKS[limit_ff.retry_off_time_field]) begin
         nxt_off = 1'b0;
      end else if (tick) begin
         nxt_retry = retry_ff + 19'h00001;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         off_ff   <= 1'b0;
         retry_ff <= 19'h00000;
      end else begin
         off_ff   <= nxt_off;
         retry_ff <= nxt_retry;
      end
   end

   // Without retry only thermal overload stops the driver; current is limited instead
   assign drv_enable = !corr_ff &&
                       (limit_ff.retry_en ? !off_ff
                                          : !drv_overtemp);
   // Analog limiter reads level only while off is clear
   assign limit_level_field = limit_ff.level;
   assign limit_off_bit     = limit_ff.off;

   // ------------------------------------------------------------
   // Registers, flags and wake pulse
   // ------------------------------------------------------------
   assign flag_rd = bus.rd && bus.addr == ADDR_FLAGS;

   // Rising edges of live faults latch; corruption also reports as power loss
   assign ev = {power_loss_event | por_ff | (corrupt_event & ~corr_ff),
                wake_detect, 1'b0,
                live[4:0] & ~prev_ff[4:0]};

   always_comb begin
      nxt_mask   = mask_ff;
      nxt_limit  = limit_ff;
      nxt_flags  = flags_ff;
      nxt_wake   = wake_ff;
      nxt_reinit = bus.wr && bus.addr == ADDR_REINIT && bus.wdata[BIT_REINIT];
      nxt_corr   = corrupt_event | (corr_ff & ~reinit_ff);
      if (reinit_ff) begin
         nxt_mask  = MASK_RST;
         nxt_limit = tfsr_limit_s'(LIMIT_RST);
         nxt_flags = FLAG_RST;
      end else if (bus.wr) begin
         // Read-only offsets fall through untouched
         if (bus.addr == ADDR_MASK) nxt_mask = bus.wdata & MASK_USED;
         if (bus.addr == ADDR_LIMIT) nxt_limit = tfsr_limit_s'(bus.wdata);
      end
      if (flag_rd) nxt_flags = FLAG_RST;
      nxt_flags = nxt_flags | ev;
      if (wake_detect && mask_ff[BIT_WAKE]) nxt_wake = WAKE_TICKS;
      else if (tick && wake_ff != 8'h00) nxt_wake = wake_ff - 8'h01;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mask_ff   <= MASK_RST;
         limit_ff  <= tfsr_limit_s'(LIMIT_RST);
         flags_ff  <= FLAG_RST;
         wake_ff   <= 8'h00;
         corr_ff   <= 1'b0;
         reinit_ff <= 1'b0;
         por_ff    <= 1'b1;
      end else begin
         mask_ff   <= nxt_mask;
         limit_ff  <= nxt_limit;
         flags_ff  <= nxt_flags;
         wake_ff   <= nxt_wake;
         corr_ff   <= nxt_corr;
         reinit_ff <= nxt_reinit;
         por_ff    <= 1'b0;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      case (bus.addr)
         ADDR_FLAGS:  rd_data = flags_ff;
         ADDR_MASK:   rd_data = mask_ff;
         ADDR_LIVE:   rd_data = live;
         ADDR_INTEG:  rd_data = {corr_ff, 7'h00};
         ADDR_REINIT: rd_data = {reinit_ff, 7'h00};
         ADDR_LIMIT:  rd_data = limit_ff;
         default:     rd_data = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // Pin outputs
   // ------------------------------------------------------------
   // Mask bit 7 never stores, so the power-loss flag always passes
   assign interrupt_wake_out_n = ~(|(flags_ff & ~mask_ff)
                                   | (wake_ff != 8'h00));
   assign rx_oe                  = ~corr_ff;
   assign aux_input_logic_out_oe = ~corr_ff;
   assign regulator_3v3_force    = corr_ff;
   assign clk_fixed_sel          = corr_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence wake_arm;
      wake_detect && mask_ff[BIT_WAKE];
   endsequence
   sequence wake_hold;
      !interrupt_wake_out_n [*8];
   endsequence

   chk_wake_level:
   assert property (flags_ff[BIT_WAKE] && !mask_ff[BIT_WAKE] |-> !interrupt_wake_out_n)
      else $error("wake flag unmasked but pin idle");

   chk_wake_pulse:
   assert property (wake_arm |=> wake_hold)
      else $error("wake pulse too short");

   chk_wake_bound:
   assert property (wake_ff <= WAKE_TICKS)
      else $error("wake pulse counter past its length");

   chk_mask_block:
   assert property (((flags_ff & ~mask_ff) == 8'h00) && wake_ff == 8'h00
                    |-> interrupt_wake_out_n)
      else $error("masked flags still drive the pin");

   chk_fault_status:
   assert property (drv_overtemp |-> live[BIT_DRVF])
      else $error("thermal overload not shown as driver fault");

   chk_uv_hyst:
   assert property (supply_below_6v || (uv_ff && !supply_above_7v) |=> uv_ff)
      else $error("undervoltage status lost without rising threshold");

   chk_corrupt_safe:
   assert property (corr_ff |-> !drv_enable && !rx_oe && !aux_input_logic_out_oe
                    && regulator_3v3_force && clk_fixed_sel)
      else $error("corrupt state not safe");

   chk_reinit_clear:
   assert property (reinit_ff |=> mask_ff == MASK_RST && limit_ff == LIMIT_RST && !reinit_ff)
      else $error("reinit did not restore defaults");

   chk_retry_off:
   assert property (limit_ff.retry_en && drv_fault && !off_ff
                    |=> !drv_enable || !limit_ff.retry_en)
      else $error("fault did not stop driver under retry");

   chk_no_retry:
   assert property (!limit_ff.retry_en && !corr_ff && !drv_overtemp |-> drv_enable)
      else $error("driver stopped without thermal overload");

   chk_flag_read:
   assert property (flag_rd && ev == 8'h00 && !reinit_ff |=> flags_ff == 8'h00)
      else $error("flag read did not clear flags");

   chk_pwr_unmasked:
   assert property (flags_ff[BIT_PWR] |-> !interrupt_wake_out_n)
      else $error("power loss flag did not assert pin");

endmodule // tfsr_regs

/* File: shared/tfsr_pkg.sv */
// Register map, field layout, timing constants and shared types of the fault/status bank
package tfsr_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_FLAGS  = 8'h00;
   localparam logic [7:0] ADDR_MASK   = 8'h01;
   localparam logic [7:0] ADDR_LIVE   = 8'h02;
   localparam logic [7:0] ADDR_INTEG  = 8'h03;
   localparam logic [7:0] ADDR_REINIT = 8'h04;
   localparam logic [7:0] ADDR_LIMIT  = 8'h05;
   localparam logic [7:0] ADDR_LAST   = ADDR_LIMIT;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int         BIT_PWR    = 7;
   localparam int         BIT_WAKE   = 6;
   localparam int         BIT_DRVF   = 4;
   localparam int         BIT_CORR   = 7;
   localparam int         BIT_REINIT = 7;
   localparam logic [7:0] MASK_USED  = 8'h5F;
   localparam logic [7:0] MASK_RST   = 8'h00;
   localparam logic [7:0] LIMIT_RST  = 8'h00;
   localparam logic [7:0] FLAG_RST   = 8'h00;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_NS    = 25;
   localparam int TICK_NS   = 1000;
   localparam int TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE_US   = 200;
   localparam int BLANK0_US = 128;
   localparam int BLANK1_US = 500;
   localparam int BLANK2_US = 1000;
   localparam int BLANK3_US = 5000;
   localparam int RETRY0_MS = 50;
   localparam int RETRY1_MS = 100;
   localparam int RETRY2_MS = 200;
   localparam int RETRY3_MS = 500;

   // Bus slave address, value is arbitrary
   localparam logic [6:0] BUS_ID = 7'h2A;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tfsr_bus_s;

   typedef struct packed {
      logic [1:0] level;
      logic       off;
      logic [1:0] blank;
      logic [1:0] retry_off_time_field;
      logic       retry_en;
   } tfsr_limit_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AACK = 3'b011,
      ST_RX   = 3'b010,
      ST_RACK = 3'b110,
      ST_TX   = 3'b111,
      ST_TACK = 3'b101
   } tfsr_i2c_e;

endpackage

/* File: verilog/tfsr_i2c_slave.sv */
// Two-wire bus slave turning byte transfers into register strobes
module tfsr_i2c_slave
   import tfsr_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Bus pins, sampled on mclk
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // Register side
   output tfsr_bus_s       bus,
   input  wire logic [7:0] rd_data
);

   tfsr_i2c_e  st_ff,  nxt_st;
   logic [7:0] sh_ff,  nxt_sh;
   logic [7:0] ptr_ff, nxt_ptr;
   logic [3:0] cnt_ff, nxt_cnt;
   logic       scl_ff, sda_ff;
   logic       rw_ff,  nxt_rw;
   logic       pok_ff, nxt_pok;
   logic       ack_ff, nxt_ack;
   logic       rise, fall, start, stop;

   // Pins are synchronous, so one sample is enough for edges
   assign rise  = scl & ~scl_ff;
   assign fall  = ~scl & scl_ff;
   assign start = scl & scl_ff & sda_ff & ~sda_in;
   assign stop  = scl & scl_ff & ~sda_ff & sda_in;

   // ------------------------------------------------------------
   // Byte engine
   // ------------------------------------------------------------
   always_comb begin
      nxt_st    = st_ff;
      nxt_sh    = sh_ff;
      nxt_ptr   = ptr_ff;
      nxt_cnt   = cnt_ff;
      nxt_rw    = rw_ff;
      nxt_pok   = pok_ff;
      nxt_ack   = ack_ff;
      bus       = '0;
      bus.addr  = ptr_ff;
      bus.wdata = sh_ff;
      if (start) begin
         nxt_st  = ST_ADDR;
         nxt_cnt = 4'h0;
      end else if (stop) begin
         nxt_st = ST_IDLE;
      end else begin
         unique case (st_ff)
            ST_IDLE: ;
            ST_ADDR, ST_RX: begin
               if (rise) begin
                  nxt_sh  = {sh_ff[6:0], sda_in};
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (fall && cnt_ff == 4'h8) begin
                  nxt_cnt = 4'h0;
                  nxt_st  = ST_RACK;
                  if (st_ff == ST_ADDR) begin
                     nxt_rw  = sh_ff[0];
                     nxt_ack = (sh_ff[7:1] == BUS_ID);
                     nxt_st  = nxt_ack ? ST_AACK : ST_IDLE;
                     // A write transfer always opens with a fresh pointer
                     if (nxt_ack && !sh_ff[0]) nxt_pok = 1'b0;
                  end else if (!pok_ff) begin
                     nxt_ptr = sh_ff;
                     nxt_ack = (sh_ff <= ADDR_LAST);
                     nxt_pok = nxt_ack;
                  end else begin
                     bus.wr  = 1'b1;
                     nxt_ptr = ptr_ff + 8'h01;
                     nxt_ack = 1'b1;
                  end
               end
            end
            ST_RACK: begin
               if (fall) nxt_st = ack_ff ? ST_RX : ST_IDLE;
            end
            ST_TX: begin
               if (rise) begin
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (fall && cnt_ff == 4'h8) begin
                  nxt_st  = ST_TACK;
                  nxt_cnt = 4'h0;
               end else if (fall) begin
                  nxt_sh = {sh_ff[6:0], 1'b0};
               end
            end
            ST_AACK, ST_TACK: begin
               if (rise && st_ff == ST_TACK) begin
                  nxt_ack = ~sda_in;
               end else if (fall) begin
                  if (!rw_ff) begin
                     nxt_st = ST_RX;
                  end else if (ack_ff) begin
                     bus.rd  = 1'b1;
                     nxt_sh  = rd_data;
                     nxt_ptr = ptr_ff + 8'h01;
                     nxt_st  = ST_TX;
                  end else begin
                     nxt_st = ST_IDLE;
                  end
               end
            end
            default: nxt_st = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_ff  <= ST_IDLE;
         sh_ff  <= 8'h00;
         ptr_ff <= 8'h00;
         cnt_ff <= 4'h0;
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
         rw_ff  <= 1'b0;
         pok_ff <= 1'b0;
         ack_ff <= 1'b0;
      end else begin
         st_ff  <= nxt_st;
         sh_ff  <= nxt_sh;
         ptr_ff <= nxt_ptr;
         cnt_ff <= nxt_cnt;
         scl_ff <= scl;
         sda_ff <= sda_in;
         rw_ff  <= nxt_rw;
         pok_ff <= nxt_pok;
         ack_ff <= nxt_ack;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe  = (st_ff == ST_AACK) | (st_ff == ST_RACK & ack_ff) |
                    (st_ff == ST_TX & ~sh_ff[7]);

endmodule // tfsr_i2c_slave

/* File: verif/tfsr_host_model.sv */
// Host-side two-wire bus master model that drives the register bank
module tfsr_host_model
   import tfsr_pkg::*;
(
   // Clock and resolved data line
   input  wire logic mclk,
   input  wire logic sda,
   // Lines driven by the host
   output logic      scl,
   output logic      sda_low,
   output logic      ack_ok
);
   timeunit 1ns;
   timeprecision 1ps;

   // Lines start released, so the bus idles high
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      ack_ok = 1'b1;
   end

   // Each phase lasts 4 mclk, a third of a bit, twice the minimum high or low time
   task automatic hold();
      repeat (4) @(posedge mclk);
   endtask

   // Data moves only while SCL is low, so it is never mistaken for start or stop
   task automatic bitx(input logic b, output logic r);
      sda_low <= !b;
      hold();
      scl <= 1'b1;
      hold();
      r = sda;
      scl <= 1'b0;
      hold();
   endtask

   // Start or repeated start
   task automatic start();
      sda_low <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
      sda_low <= 1'b1;
      hold();
      scl <= 1'b0;
      hold();
   endtask

   // Stop
   task automatic stop();
      sda_low <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      sda_low <= 1'b0;
      hold();
   endtask

   // Byte out MSB first; the ninth bit is the device acknowledge
   task automatic send(input logic [7:0] d);
      logic [7:0] q;
      logic       a;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], q[i]);
      end
      bitx(1'b1, a);
      ack_ok = ack_ok & !a;
   endtask

   // Register write: address, pointer, one data byte
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      ack_ok = 1'b1;
      start();
      send({BUS_ID, 1'b0});
      send(p);
      send(d);
      stop();
   endtask

   // Register read of one byte, ended by the host's not-acknowledge
   task automatic rd(input logic [7:0] p, output logic [7:0] q);
      logic a;
      ack_ok = 1'b1;
      start();
      send({BUS_ID, 1'b0});
      send(p);
      start();
      send({BUS_ID, 1'b1});
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, q[i]);
      end
      bitx(1'b1, a);
      stop();
   endtask
endmodule // tfsr_host_model

/* File: verif/tfsr_regs_tb_top.sv */
// Self-checking bench of the fault and status register bank
module tfsr_regs_tb_top
   import tfsr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = TICK_CYC;

   logic       mclk = 1'b0;
   logic       resetn, scl, sda_low, sda_oe, sda_out, host_ack, drv_en, lim_off;
   logic       line_low, aux_low, ovc, wake, ploss, corr, rx_oe, li_oe, v33, clk_sel, irq_n, hyst;
   logic [4:0] cond;
   logic [1:0] lim_lvl;
   int         error_cnt = 0;
   int         tests_run = 0;
   // Open-drain data line with pull-up
   wire        sda = !sda_low && (sda_oe ? sda_out : 1'b1);

   // 40 MHz clock
   always #12.5 mclk = !mclk;

   tfsr_host_model u_tfsr_host_model (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low),
      .ack_ok(host_ack));
   // Short tick counts keep the run brief
   tfsr_regs #(.WAKE_TICKS(8'h04), .BLANK_TICKS({13'h8, 13'h6, 13'h4, 13'h2}),
      .RETRY_TICKS({19'h28, 19'h1E, 19'h14, 19'h0A})) u_tfsr_regs (
      .mclk(mclk), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .line_low(line_low), .aux_low(aux_low), .drv_overcurrent(ovc),
      .drv_overtemp(cond[4]), .supply_below_16v(cond[3]), .supply_below_6v(cond[2]),
      .supply_above_7v(!cond[2] && !hyst), .die_above_shutdown(cond[1]),
      .die_above_140c(cond[0]), .die_below_125c(!cond[0] && !hyst),
      .wake_detect(wake), .power_loss_event(ploss),
      .corrupt_event(corr), .drv_enable(drv_en), .limit_level_field(lim_lvl),
      .limit_off_bit(lim_off), .rx_oe(rx_oe), .aux_input_logic_out_oe(li_oe),
      .regulator_3v3_force(v33), .clk_fixed_sel(clk_sel), .interrupt_wake_out_n(irq_n));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Read and compare, also checking every device acknowledge
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] q;
      u_tfsr_host_model.rd(p, q);
      chk(8'(host_ack), 8'h01);
      chk(q, e);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected 30000 cycles
   initial begin
      repeat (60000) @(posedge mclk);
      error_cnt++;
      summarize();
   end

   initial begin
      {resetn, line_low, aux_low, ovc, wake, ploss, corr, hyst, cond} <= '0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(8'(irq_n), 8'h00);
      rd(ADDR_FLAGS, 8'h80);
      u_tfsr_host_model.wr(ADDR_MASK, 8'hFF);
      rd(ADDR_MASK, 8'h5F);
      // Each fault bit once unmasked, once masked
      for (int i = 0; i < 10; i++) begin
         u_tfsr_host_model.wr(ADDR_MASK, (i % 2) ? 8'(1 << (i / 2)) : 8'h00);
         cond <= 5'(1 << (i / 2));
         repeat (8) @(posedge mclk);
         rd(ADDR_LIVE, 8'(1 << (i / 2)));
         chk(8'(irq_n), 8'(i % 2));
         cond <= 5'h00;
         rd(ADDR_FLAGS, 8'(1 << (i / 2)));
         chk(8'(irq_n), 8'h01);
      end
      // Between the two thresholds neither comparator fires, so both bits must hold
      cond <= 5'h05;
      repeat (4) @(posedge mclk);
      {hyst, cond} <= 6'h20;
      rd(ADDR_LIVE, 8'h05);
      hyst <= 1'b0;
      rd(ADDR_LIVE, 8'h00);
      rd(ADDR_FLAGS, 8'h05);
      // Wake with mask clear holds the pin, with mask set only pulses it
      for (int m = 0; m < 2; m++) begin
         u_tfsr_host_model.wr(ADDR_MASK, 8'(m << 6));
         wake <= 1'b1;
         @(posedge mclk) wake <= 1'b0;
         repeat (2) @(posedge mclk);
         chk(8'(irq_n), 8'h00);
         repeat (6 * TK) @(posedge mclk);
         chk(8'(irq_n), 8'(m));
         rd(ADDR_FLAGS, 8'h40);
      end
      for (int l = 0; l < 4; l++) begin
         u_tfsr_host_model.wr(ADDR_LIMIT, 8'(l << 6) | 8'h38);
         rd(ADDR_LIMIT, 8'(l << 6) | 8'h38);
         chk(8'({lim_off, lim_lvl}), 8'(l + 4));
      end
      // Overcurrent without, then with auto-retry at the 20-tick off-time
      u_tfsr_host_model.wr(ADDR_LIMIT, 8'h00);
      ovc <= 1'b1;
      repeat (4 * TK) @(posedge mclk);
      chk(8'(drv_en), 8'h01);
      ovc <= 1'b0;
      u_tfsr_host_model.wr(ADDR_LIMIT, 8'h03);
      ovc <= 1'b1;
      repeat (4 * TK) @(posedge mclk);
      ovc <= 1'b0;
      chk(8'(drv_en), 8'h00);
      repeat (15 * TK) @(posedge mclk);
      chk(8'(drv_en), 8'h00);
      repeat (10 * TK) @(posedge mclk);
      chk(8'(drv_en), 8'h01);
      rd(ADDR_FLAGS, 8'h10);
      // Corruption enters the safe state; soft reinit restores defaults
      u_tfsr_host_model.wr(ADDR_MASK, 8'h5F);
      corr <= 1'b1;
      @(posedge mclk) corr <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(8'({rx_oe, li_oe, v33, clk_sel, drv_en, irq_n}), 8'h0C);
      rd(ADDR_INTEG, 8'h80);
      u_tfsr_host_model.wr(ADDR_REINIT, 8'h80);
      rd(ADDR_INTEG, 8'h00);
      rd(ADDR_MASK, 8'h00);
      rd(ADDR_LIMIT, 8'h00);
      rd(ADDR_REINIT, 8'h00);
      rd(ADDR_FLAGS, 8'h00);
      line_low <= 1'b1;
      aux_low <= 1'b1;
      u_tfsr_host_model.wr(ADDR_LIVE, 8'h1F);
      rd(ADDR_LIVE, 8'hC0);
      summarize();
   end
endmodule // tfsr_regs_tb_top
